// *** shared/ghr_pkg.sv ***
package ghr_pkg;

    // ----------------------------------------
    // Clock and timing
    // ----------------------------------------
    localparam int CLK_MHZ = 200;
    localparam int DEAD_MAX_NS = 2000;
    localparam int DEAD_STEP_NS = 250;
    localparam int BLANK_MAX_NS = 4000;
    localparam int DEAD_STEP_CYC = (DEAD_STEP_NS * CLK_MHZ) / 1000;
    localparam int BLANK_MAX_CYC = (BLANK_MAX_NS * CLK_MHZ) / 1000;
    localparam int DEAD_CYC_W = 9;
    localparam int BLANK_CYC_W = 10;
    localparam logic [3:0] DEAD_CODES = 4'h8;

    // ----------------------------------------
    // Current-limit reference scale
    // ----------------------------------------
    localparam int DAC_LSB_UV = 13770;
    localparam int DAC_BASE_MV = 991;

    // ----------------------------------------
    // Response code layout
    // ----------------------------------------
    localparam int CODE_ACK_BIT = 6;
    localparam int CODE_UNSOL_BIT = 7;
    localparam logic [5:0] ID_SET_CFG0 = 6'h01;
    localparam logic [5:0] ID_GET_CFG0 = 6'h02;
    localparam logic [5:0] ID_SET_DAC = 6'h03;
    localparam logic [5:0] ID_GET_DAC = 6'h04;
    localparam logic [5:0] ID_STATUS0 = 6'h05;
    localparam logic [5:0] ID_STATUS1 = 6'h06;
    localparam logic [5:0] ID_SET_CFG2 = 6'h07;
    localparam logic [5:0] ID_GET_CFG2 = 6'h08;

    // ----------------------------------------
    // Register fields and reset values
    // ----------------------------------------
    localparam logic [7:0] DAC_RST = 8'h00;
    localparam logic [7:0] CFG0_RST = 8'h00;
    localparam logic [7:0] CFG2_RST = 8'h00;
    localparam logic [7:0] CFG0_RSVD_MASK = 8'h80;
    localparam logic [7:0] CFG2_RSVD_MASK = 8'he0;
    localparam int DT_LSB = 2;
    localparam int DT_W = 3;
    localparam int BL_LSB = 0;
    localparam int BL_W = 2;
    localparam int ST1_EXT_UVLO = 2;
    localparam int ST1_EXT_OC = 3;
    localparam int ST1_BOR = 4;
    localparam int ST1_LDO5_UVLO = 5;
    localparam logic [7:0] ST_NORMAL = 8'h00;
    localparam int SYNC_W = 12;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [2:0] {
        REQ_SET_CFG0,
        REQ_GET_CFG0,
        REQ_SET_DAC,
        REQ_GET_DAC,
        REQ_GET_ST0,
        REQ_GET_ST1,
        REQ_SET_CFG2,
        REQ_GET_CFG2
    } ghr_req_kind_t;

    typedef struct packed {
        ghr_req_kind_t kind;
        logic [7:0] data;
        logic bad;
    } ghr_req_t;

    typedef struct packed {
        logic [7:0] code;
        logic [7:0] data;
    } ghr_msg_t;

    typedef struct packed {
        logic ldo5_uvlo;
        logic bor_event;
        logic ext_oc;
        logic ext_uvlo;
    } ghr_st1_src_t;

endpackage : ghr_pkg

// *** hw/ghr_sync.sv ***
`timescale 1ns/1ps
module ghr_sync import ghr_pkg::*; #(
    parameter int W = 1
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    // ----------------------------------------
    // Two-stage synchroniser
    // ----------------------------------------
    logic [W-1:0] meta_q;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end

endmodule : ghr_sync

// *** hw/ghr_encoder.sv ***
// Behaviour
// R1: Set current-limit reply: code 0x03 nack or 0x43 ack, then DAC byte.
// R2: Get current-limit reply: code 0x04 nack or 0x44 ack, then present DAC byte.
// R3: DAC byte spans 00..ff, 13.77 mV per count above 0.991 V.
// R4: Status 0 reply: code 0x05 nack or 0x45 ack, then flag byte.
// R5: Status 0 may be sent unsolicited; host accepts it anytime.
// R6: Status 0 zero normally; bits 0..4 temperature and supply faults.
// R7: Status 0 bits 5..7 buck overcurrent, undervoltage warning, brown-out.
// R8: Status 1 codes: 0x06 nack, 0x46 ack, 0x86 unsolicited.
// R9: Status 1 bits 2,3,5 faults; bits 0,1,6,7 reserved zero.
// R10: Status 1 bit 4 brown-out config lost, set after start-up.
// R11: Set config 2 reply: code 0x07 nack or 0x47 ack, then contents.
// R12: Get config 2 reply: code 0x08 nack or 0x48 ack, then contents.
// R13: Config 2 bits 4:2 dead time, 2000 ns down by 250 ns steps.
// R14: Config 2 bits 1:0 blanking 4 us, 2 us, 1 us, 500 ns.
// R15: Set config 0 reply: code 0x01 nack or 0x41 ack.
// R16: Host reads bit 6 as ack, bit 7 unsolicited, low six as type.
`timescale 1ns/1ps
module ghr_encoder import ghr_pkg::*; (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic req_valid,
    output logic req_ready,
    input wire ghr_req_t req,
    input wire logic [7:0] fault0_pins,
    input wire ghr_st1_src_t fault1_pins,
    output logic tx_valid,
    input wire logic tx_ready,
    output logic [7:0] tx_byte,
    output logic [7:0] dac_ref,
    output logic [7:0] cfg0,
    output logic [7:0] cfg2,
    output logic [DEAD_CYC_W-1:0] dead_cycles,
    output logic [BLANK_CYC_W-1:0] blank_cycles,
    output logic config_lost
);

    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    logic rst_meta_q;
    logic rst_n_q;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // ----------------------------------------
    // Fault inputs
    // ----------------------------------------
    // Analog comparators are asynchronous to clk_sys
    logic [SYNC_W-1:0] sync_q;
    logic [7:0] st0_now;
    ghr_st1_src_t st1_src;

    ghr_sync #(.W(SYNC_W)) u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n_q),
        .d({fault0_pins, fault1_pins}),
        .q(sync_q)
    );

    assign st0_now = sync_q[SYNC_W-1:4]; // R6 R7
    assign st1_src = sync_q[3:0];

    // ----------------------------------------
    // Register state
    // ----------------------------------------
    typedef enum logic [1:0] {
        S_IDLE,
        S_CODE,
        S_DATA
    } ghr_state_t;

    ghr_state_t state_q;
    ghr_state_t state_d;
    ghr_msg_t msg_q;
    ghr_msg_t msg_d;
    logic [7:0] dac_q;
    logic [7:0] cfg0_q;
    logic [7:0] cfg2_q;
    logic bor_q;
    logic [7:0] st0_sent_q;
    logic [7:0] st1_sent_q;
    logic [7:0] st1_now;
    logic take;
    logic ack;
    logic unsol;
    logic send0;
    logic send1;
    logic [5:0] msg_id;
    logic [7:0] msg_data;
    logic req_ready_q;
    logic tx_valid_q;
    logic [7:0] tx_byte_q;
    logic [DEAD_CYC_W-1:0] dead_q;
    logic [BLANK_CYC_W-1:0] blank_q;

    // Reserved bits forced to zero
    always_comb begin
        st1_now = ST_NORMAL;
        st1_now[ST1_EXT_UVLO] = st1_src.ext_uvlo; // R9
        st1_now[ST1_EXT_OC] = st1_src.ext_oc; // R9
        st1_now[ST1_BOR] = bor_q; // R10
        st1_now[ST1_LDO5_UVLO] = st1_src.ldo5_uvlo; // R9
    end

    // ----------------------------------------
    // Message selection
    // ----------------------------------------
    // Replies outrank unsolicited reports so a host poll is never starved
    always_comb begin
        take = 1'b0;
        send0 = 1'b0;
        send1 = 1'b0;
        ack = 1'b0;
        unsol = 1'b0;
        msg_id = ID_STATUS0;
        msg_data = ST_NORMAL;
        if (state_q == S_IDLE) begin
            if (req_valid && req_ready_q) begin
                take = 1'b1;
                ack = !req.bad;
                unique case (req.kind)
                    REQ_SET_CFG0: begin
                        ack = !req.bad && ((req.data & CFG0_RSVD_MASK) == 8'h00);
                        msg_id = ID_SET_CFG0; // R15
                        msg_data = ack ? req.data : cfg0_q;
                    end
                    REQ_GET_CFG0: begin
                        msg_id = ID_GET_CFG0;
                        msg_data = cfg0_q;
                    end
                    REQ_SET_DAC: begin
                        msg_id = ID_SET_DAC; // R1
                        msg_data = ack ? req.data : dac_q; // R3
                    end
                    REQ_GET_DAC: begin
                        msg_id = ID_GET_DAC; // R2
                        msg_data = dac_q;
                    end
                    REQ_GET_ST0: begin
                        msg_id = ID_STATUS0; // R4
                        msg_data = st0_now;
                        send0 = 1'b1;
                    end
                    REQ_GET_ST1: begin
                        msg_id = ID_STATUS1; // R8
                        msg_data = st1_now;
                        send1 = 1'b1;
                    end
                    REQ_SET_CFG2: begin
                        ack = !req.bad && ((req.data & CFG2_RSVD_MASK) == 8'h00);
                        msg_id = ID_SET_CFG2; // R11
                        msg_data = ack ? req.data : cfg2_q;
                    end
                    REQ_GET_CFG2: begin
                        msg_id = ID_GET_CFG2; // R12
                        msg_data = cfg2_q;
                    end
                endcase
            end else if (st1_now != st1_sent_q) begin
                unsol = 1'b1; // R8
                send1 = 1'b1;
                msg_id = ID_STATUS1;
                msg_data = st1_now;
            end else if (st0_now != st0_sent_q) begin
                unsol = 1'b1; // R5
                send0 = 1'b1;
                msg_id = ID_STATUS0;
                msg_data = st0_now;
            end
        end
        msg_d.code = {unsol, ack, msg_id}; // R16
        msg_d.data = msg_data;
    end

    // ----------------------------------------
    // Link sequencer
    // ----------------------------------------
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            S_IDLE: begin
                if (take || send0 || send1) begin
                    state_d = S_CODE;
                end
            end
            S_CODE: begin
                if (tx_ready) begin
                    state_d = S_DATA;
                end
            end
            S_DATA: begin
                if (tx_ready) begin
                    state_d = S_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q <= S_IDLE;
            msg_q <= '0;
            req_ready_q <= 1'b0;
            tx_valid_q <= 1'b0;
            tx_byte_q <= 8'h00;
        end else begin
            state_q <= state_d;
            req_ready_q <= (state_d == S_IDLE);
            tx_valid_q <= (state_d != S_IDLE);
            if (state_q == S_IDLE) begin
                msg_q <= msg_d;
                tx_byte_q <= msg_d.code;
            end else if (state_q == S_CODE && tx_ready) begin
                tx_byte_q <= msg_q.data;
            end
        end
    end

    // ----------------------------------------
    // Last reported status
    // ----------------------------------------
    // Change against last report cannot lose an edge, unlike a pulse flag
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            st0_sent_q <= ST_NORMAL;
            st1_sent_q <= ST_NORMAL;
        end else begin
            if (send0) begin
                st0_sent_q <= st0_now; // R5
            end
            if (send1) begin
                st1_sent_q <= st1_now;
            end
        end
    end

    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            dac_q <= DAC_RST;
            cfg0_q <= CFG0_RST;
            cfg2_q <= CFG2_RST;
        end else if (take && ack) begin
            if (req.kind == REQ_SET_DAC) begin
                dac_q <= req.data; // R3
            end
            if (req.kind == REQ_SET_CFG0) begin
                cfg0_q <= req.data;
            end
            if (req.kind == REQ_SET_CFG2) begin
                cfg2_q <= req.data; // R13 R14
            end
        end
    end

    // Set wins over the clear by a restoring config write
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            bor_q <= 1'b1; // R10
        end else if (st1_src.bor_event) begin
            bor_q <= 1'b1;
        end else if (take && ack && req.kind == REQ_SET_CFG0) begin
            bor_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // Timing decode
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            dead_q <= DEAD_CYC_W'(DEAD_MAX_NS * CLK_MHZ / 1000);
            blank_q <= BLANK_CYC_W'(BLANK_MAX_CYC);
        end else begin
            dead_q <= DEAD_CYC_W'((DEAD_CODES - {1'b0, cfg2_q[DT_LSB +: DT_W]}) * DEAD_STEP_CYC); // R13
            blank_q <= BLANK_CYC_W'(BLANK_MAX_CYC) >> cfg2_q[BL_LSB +: BL_W]; // R14
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign req_ready = req_ready_q;
    assign tx_valid = tx_valid_q;
    assign tx_byte = tx_byte_q;
    assign dac_ref = dac_q;
    assign cfg0 = cfg0_q;
    assign cfg2 = cfg2_q;
    assign dead_cycles = dead_q;
    assign blank_cycles = blank_q;
    assign config_lost = bor_q;

endmodule : ghr_encoder

// *** test/ghr_encoder_sva.sv ***
`timescale 1ns/1ps
module ghr_encoder_chk import ghr_pkg::*; (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic [7:0] tx_byte,
    input wire logic [7:0] dac_ref,
    input wire logic [7:0] cfg2,
    input wire logic [DEAD_CYC_W-1:0] dead_cycles,
    input wire logic [BLANK_CYC_W-1:0] blank_cycles
);
    // ----
    // Byte phase tracking
    // ----
    logic data_q;
    logic [7:0] code_q;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            data_q <= 1'b0;
        end else if (tx_valid && tx_ready) begin
            data_q <= !data_q;
        end
    end
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            code_q <= 8'h00;
        end else if (tx_valid && tx_ready && !data_q) begin
            code_q <= tx_byte;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // ----
    // Properties
    // ----
    AST_TAKE: assert property (req_valid && req_ready |=> tx_valid && !req_ready && !data_q)
        else $error("no code byte after take");
    AST_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
        else $error("byte dropped while stalled");
    AST_CODE: assert property (tx_valid && !data_q |-> tx_byte[5:0] inside {[6'h01:6'h08]} &&
        !(tx_byte[7] && tx_byte[6]) && (!tx_byte[7] || tx_byte[5:0] inside {6'h05, 6'h06}))
        else $error("bad code byte");
    AST_DAC: assert property (tx_valid && data_q && code_q inside {8'h43, 8'h44} |-> tx_byte == dac_ref)
        else $error("dac byte mismatch");
    AST_CFG2: assert property (tx_valid && data_q && code_q inside {8'h47, 8'h48} |-> tx_byte == cfg2)
        else $error("cfg2 byte mismatch");
    AST_ST1: assert property (tx_valid && data_q && code_q[5:0] == 6'h06 |-> (tx_byte & 8'hc3) == 8'h00)
        else $error("status1 reserved bit set");
    AST_RSVD: assert property (cfg2[7:5] == 3'b000)
        else $error("cfg2 reserved bits set");
    AST_DEAD: assert property (1'b1 |=> dead_cycles == 9'h190 - 9'h032 * $past(cfg2[4:2]))
        else $error("dead time mismatch");
    AST_BLANK: assert property (1'b1 |=> blank_cycles == (10'h320 >> $past(cfg2[1:0])))
        else $error("blanking mismatch");
endmodule : ghr_encoder_chk

bind ghr_encoder ghr_encoder_chk u_ghr_encoder_chk (.clk_sys(clk_sys), .resetn(resetn),
    .req_valid(req_valid), .req_ready(req_ready), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_byte(tx_byte), .dac_ref(dac_ref), .cfg2(cfg2), .dead_cycles(dead_cycles),
    .blank_cycles(blank_cycles));

// *** test/ghr_host_model.sv ***
`timescale 1ns/1ps
module ghr_host_model (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic slow,
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [7:0] tx_byte,
    output logic [15:0] last_msg,
    output int msg_cnt
);
    // ----
    // Byte sink, optionally ready one cycle in four
    // ----
    logic [1:0] pace_q;
    logic [7:0] code_q;
    logic second_q;
    // Accepts any message at any time, solicited or not
    assign tx_ready = !slow || pace_q == 2'h3;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pace_q <= 2'h0;
            code_q <= 8'h00;
            second_q <= 1'b0;
            last_msg <= 16'h0000;
            msg_cnt <= 0;
        end else begin
            pace_q <= pace_q + 2'h1;
            if (tx_valid && tx_ready) begin
                second_q <= !second_q;
                code_q <= tx_byte;
                if (second_q) begin
                    last_msg <= {code_q, tx_byte};
                    msg_cnt <= msg_cnt + 1;
                end
            end
        end
    end
endmodule : ghr_host_model

// *** test/tb_ghr_encoder.sv ***
`timescale 1ns/1ps
module tb_ghr_encoder import ghr_pkg::*;;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic req_valid = 1'b0;
    logic slow = 1'b0;
    logic req_ready, tx_valid, tx_ready, config_lost;
    ghr_req_t req = '0;
    logic [7:0] fault0_pins = 8'h00;
    logic [7:0] tx_byte, dac_ref, cfg0, cfg2;
    ghr_st1_src_t fault1_pins = '0;
    logic [DEAD_CYC_W-1:0] dead_cycles;
    logic [BLANK_CYC_W-1:0] blank_cycles;
    logic [15:0] last_msg;
    int msg_cnt;
    int error_cnt = 0;
    int checked = 0;

    ghr_encoder u_ghr_encoder (.clk_sys(clk_sys), .resetn(resetn), .req_valid(req_valid),
        .req_ready(req_ready), .req(req), .fault0_pins(fault0_pins), .fault1_pins(fault1_pins),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_byte(tx_byte), .dac_ref(dac_ref), .cfg0(cfg0),
        .cfg2(cfg2), .dead_cycles(dead_cycles), .blank_cycles(blank_cycles), .config_lost(config_lost));
    ghr_host_model u_ghr_host_model (.clk_sys(clk_sys), .resetn(resetn), .slow(slow), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .tx_byte(tx_byte), .last_msg(last_msg), .msg_cnt(msg_cnt));

    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end
    // ----
    // Tasks
    // ----
    task automatic tally_and_finish;
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic wait_msg(input logic [15:0] exp);
        int n;
        n = msg_cnt;
        for (int i = 0; i < 400 && msg_cnt == n; i++) begin
            @(posedge clk_sys);
            #1;
        end
        if (msg_cnt == n) begin
            error_cnt++;
            $display("Error at %0t: no message before limit", $time);
        end
        check(last_msg, exp);
    endtask : wait_msg
    task automatic xfer(input ghr_req_kind_t kind, input logic [7:0] data, input logic bad,
        input logic [15:0] exp);
        req_valid = 1'b1;
        req = '{kind: kind, data: data, bad: bad};
        for (int i = 0; i < 400 && req_ready !== 1'b1; i++) begin
            @(posedge clk_sys);
            #1;
        end
        if (req_ready !== 1'b1) begin
            error_cnt++;
            $display("Error at %0t: request never accepted", $time);
        end
        @(posedge clk_sys);
        #1;
        req_valid = 1'b0;
        wait_msg(exp);
    endtask : xfer
    // ----
    // Scenarios
    // ----
    initial begin
        repeat (16) @(posedge clk_sys);
        #1;
        resetn = 1'b1;
        check(16'(config_lost), 16'h0001);
        wait_msg(16'h8610);
        xfer(REQ_SET_DAC, 8'hff, 1'b0, {2'b01, ID_SET_DAC, 8'hff});
        check(16'(dac_ref), 16'h00ff);
        xfer(REQ_SET_DAC, 8'h12, 1'b1, {2'b00, ID_SET_DAC, 8'hff});
        xfer(REQ_GET_DAC, 8'h00, 1'b0, {2'b01, ID_GET_DAC, 8'hff});
        xfer(REQ_SET_DAC, 8'h00, 1'b0, {2'b01, ID_SET_DAC, 8'h00});
        // Paced sink exercises the byte hold
        slow = 1'b1;
        for (int i = 0; i < 8; i++) begin
            xfer(REQ_SET_CFG2, {3'b000, i[2:0], i[1:0]}, 1'b0, {2'b01, ID_SET_CFG2, 3'b000, i[2:0], i[1:0]});
            check(16'(dead_cycles), 16'((DEAD_MAX_NS - DEAD_STEP_NS * i) / 5));
            check(16'(blank_cycles), 16'((BLANK_MAX_NS >> i[1:0]) / 5));
        end
        xfer(REQ_SET_CFG2, 8'h20, 1'b0, {2'b00, ID_SET_CFG2, 8'h1f});
        xfer(REQ_GET_CFG2, 8'h00, 1'b0, {2'b01, ID_GET_CFG2, 8'h1f});
        slow = 1'b0;
        for (int b = 0; b < 8; b++) begin
            fault0_pins = 8'h01 << b;
            wait_msg({8'h85, 8'h01 << b});
        end
        xfer(REQ_GET_ST0, 8'h00, 1'b0, 16'h4580);
        xfer(REQ_GET_ST0, 8'h00, 1'b1, 16'h0580);
        fault0_pins = 8'h00;
        wait_msg(16'h8500);
        fault1_pins = '{ldo5_uvlo: 1'b1, bor_event: 1'b0, ext_oc: 1'b1, ext_uvlo: 1'b1};
        wait_msg(16'h863c);
        xfer(REQ_GET_ST1, 8'h00, 1'b0, 16'h463c);
        xfer(REQ_GET_ST1, 8'h00, 1'b1, 16'h063c);
        xfer(REQ_SET_CFG0, 8'h05, 1'b0, {2'b01, ID_SET_CFG0, 8'h05});
        wait_msg(16'h862c);
        check(16'(config_lost), 16'h0000);
        check(16'(cfg0), 16'h0005);
        xfer(REQ_SET_CFG0, 8'h85, 1'b0, {2'b00, ID_SET_CFG0, 8'h05});
        check(16'(cfg0), 16'h0005);
        xfer(REQ_GET_CFG0, 8'h00, 1'b0, {2'b01, ID_GET_CFG0, 8'h05});
        fault1_pins = '0;
        wait_msg(16'h8600);
        tally_and_finish();
    end
    initial begin
        #200000;
        error_cnt++;
        tally_and_finish();
    end
endmodule : tb_ghr_encoder
